/* logic/ogs_defs.svh */
`ifndef OGS_DEFS_SVH
`define OGS_DEFS_SVH

// parallel word width taken from the core
`define OGS_WORD_W 8
// bit counter width, holds 0..7
`define OGS_CNT_W 3
// serial bits per word in each mode
`define OGS_LEN_7TO1 3'h7
`define OGS_LEN_8TO1 3'h0
`define OGS_LEN_4TO1 3'h4
// last count value of each word period
`define OGS_LAST_7TO1 3'h6
`define OGS_LAST_8TO1 3'h7
`define OGS_LAST_4TO1 3'h3
// nibble split for the dual mode
`define OGS_NIB_W 4
// reset values
`define OGS_RST_WORD 8'h00
`define OGS_RST_CNT 3'h0
`define OGS_RST_BIT 1'h0

`endif

/* logic/ogs_pkg.sv */
package ogs_pkg;

  // gearbox mode, static while running
  typedef enum logic [1:0] {
    OGS_MODE_7TO1 = 2'h0,
    OGS_MODE_8TO1 = 2'h1,
    OGS_MODE_DUAL_4TO1 = 2'h2
  } ogs_mode_t;

  // output gating state, one-hot
  typedef enum logic [1:0] {
    OGS_ST_FILL = 2'h1,
    OGS_ST_RUN = 2'h2
  } ogs_state_t;

endpackage : ogs_pkg

/* logic/ogs_lane_if.sv */
`timescale 1ns/1ps
interface ogs_lane_if #(parameter int W = 8);
  logic xfer;
  logic load;
  logic [W-1:0] word;
  logic ser;

  modport ctrl (output xfer, output load, output word, input ser);
  modport lane (input xfer, input load, input word, output ser);
endinterface : ogs_lane_if

/* logic/ogs_lane.sv */
`timescale 1ns/1ps
`include "ogs_defs.svh"
module ogs_lane #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // stage control and data
  ogs_lane_if.lane lane_if
);

  logic [W-1:0] hold_reg;
  logic [W-1:0] hold_next;
  logic [W-1:0] shift_reg;
  logic [W-1:0] shift_next;

  ////////////////////////////////////////////////////////////////
  // second stage takes the word, third stage shifts it out
  always_comb begin
    hold_next = hold_reg;
    shift_next = {1'b0, shift_reg[W-1:1]}; // zero fill keeps the line low past a short word
    if (lane_if.xfer) begin
      hold_next = lane_if.word;
    end
    if (lane_if.load) begin
      shift_next = hold_reg;
    end
  end

  // registers only; reset clears both stages
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      hold_reg <= '0;
      shift_reg <= '0;
    end else begin
      hold_reg <= hold_next;
      shift_reg <= shift_next;
    end
  end

  assign lane_if.ser = shift_reg[0];

endmodule : ogs_lane

/* logic/ogs_top.sv */
`timescale 1ns/1ps
`include "ogs_defs.svh"
// Notes on behaviour
// - one gearbox serialises up to eight bits
// - modes: 7:1, one 8:1, two 4:1
// - lanes take D[6:0], D[7:0], D[3:0]/D[7:4]
// - three register stages input to output
// - first stage captures on slow tick
// - second stage moves word to fast side
// - third stage shifts bits out serially
module ogs_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // configuration
  input wire ogs_pkg::ogs_mode_t mode_i,
  // parallel side
  input wire logic [`OGS_WORD_W-1:0] data_i,
  output logic word_taken_o,
  // serial side
  output logic serial_first_o,
  output logic serial_second_o
);

  ////////////////////////////////////////////////////////////////
  // word period divider, one fast cycle per serial bit

  logic [`OGS_CNT_W-1:0] cnt_reg;
  logic [`OGS_CNT_W-1:0] cnt_next;
  logic [`OGS_CNT_W-1:0] last_cnt;
  logic slow_tick;
  logic xfer_tick;

  // word length follows the mode
  always_comb begin
    unique case (mode_i)
      ogs_pkg::OGS_MODE_7TO1: last_cnt = `OGS_LAST_7TO1;
      ogs_pkg::OGS_MODE_8TO1: last_cnt = `OGS_LAST_8TO1;
      ogs_pkg::OGS_MODE_DUAL_4TO1: last_cnt = `OGS_LAST_4TO1;
      default: last_cnt = `OGS_LAST_8TO1; // unused code, treat as 8:1
    endcase
  end

  // slow rate is an enable pulse, not a second clock
  always_comb begin
    slow_tick = (cnt_reg == last_cnt);
    xfer_tick = (cnt_reg == `OGS_RST_CNT);
    cnt_next = slow_tick ? `OGS_RST_CNT : cnt_reg + 3'h1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_reg <= `OGS_RST_CNT;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // first stage: capture the core word, masked per mode

  logic [`OGS_WORD_W-1:0] cap_reg;
  logic [`OGS_WORD_W-1:0] cap_next;

  always_comb begin
    cap_next = cap_reg;
    if (slow_tick) begin
      unique case (mode_i)
        ogs_pkg::OGS_MODE_7TO1: cap_next = {1'b0, data_i[6:0]}; // bit 7 ignored
        default: cap_next = data_i;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cap_reg <= `OGS_RST_WORD;
    end else begin
      cap_reg <= cap_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // lanes: first cell always used, second only in dual 4:1

  ogs_lane_if #(.W(`OGS_WORD_W)) first_if ();
  ogs_lane_if #(.W(`OGS_WORD_W)) second_if ();

  logic dual_mode;

  // hold stage loads one cycle after capture, shifter reloads on the word edge
  always_comb begin
    dual_mode = (mode_i == ogs_pkg::OGS_MODE_DUAL_4TO1);
    first_if.xfer = xfer_tick;
    first_if.load = slow_tick;
    first_if.word = dual_mode ? {4'h0, cap_reg[`OGS_NIB_W-1:0]} : cap_reg;
    second_if.xfer = xfer_tick && dual_mode;
    second_if.load = slow_tick;
    second_if.word = {4'h0, cap_reg[`OGS_WORD_W-1:`OGS_NIB_W]};
  end

  ogs_lane #(.W(`OGS_WORD_W)) u_first (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .lane_if(first_if.lane)
  );

  ogs_lane #(.W(`OGS_WORD_W)) u_second (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .lane_if(second_if.lane)
  );

  ////////////////////////////////////////////////////////////////
  // output gating: low until the first captured word reaches the shifter

  ogs_pkg::ogs_state_t state_reg;
  ogs_pkg::ogs_state_t state_next;
  logic [1:0] fill_reg;
  logic [1:0] fill_next;
  logic q_first_reg;
  logic q_first_next;
  logic q_second_reg;
  logic q_second_next;

  // fill counts word edges: capture, then shifter load
  always_comb begin
    state_next = state_reg;
    fill_next = fill_reg;
    unique case (state_reg)
      ogs_pkg::OGS_ST_FILL: begin
        if (slow_tick) begin
          fill_next = fill_reg + 2'h1;
          if (fill_reg == 2'h1) begin
            state_next = ogs_pkg::OGS_ST_RUN; // shifter now holds real data
          end
        end
      end
      ogs_pkg::OGS_ST_RUN: begin
        state_next = ogs_pkg::OGS_ST_RUN;
      end
      default: begin
        state_next = ogs_pkg::OGS_ST_FILL;
      end
    endcase
  end

  // registered serial outputs, the third stage's retiming flop
  always_comb begin
    q_first_next = (state_next == ogs_pkg::OGS_ST_RUN) ? first_if.ser : `OGS_RST_BIT;
    q_second_next = (state_next == ogs_pkg::OGS_ST_RUN && dual_mode) ? second_if.ser : `OGS_RST_BIT;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_reg <= ogs_pkg::OGS_ST_FILL;
      fill_reg <= 2'h0;
      q_first_reg <= `OGS_RST_BIT;
      q_second_reg <= `OGS_RST_BIT;
    end else begin
      state_reg <= state_next;
      fill_reg <= fill_next;
      q_first_reg <= q_first_next;
      q_second_reg <= q_second_next;
    end
  end

  // outputs
  assign serial_first_o = q_first_reg;
  assign serial_second_o = q_second_reg;
  assign word_taken_o = slow_tick; // core must present the next word here

endmodule : ogs_top

/* test/ogs_top_monitor.sv */
`timescale 1ns/1ps
`include "ogs_defs.svh"
// watches cadence, bit order and reset at the gearbox ports
module ogs_top_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // observed ports
  input wire ogs_pkg::ogs_mode_t mode_i,
  input wire logic [`OGS_WORD_W-1:0] data_i,
  input wire logic word_taken_o,
  input wire logic serial_first_o,
  input wire logic serial_second_o
);
  logic m7, m8, m4;
  // mode decode, code 3 left to the bench
  assign m7 = mode_i == ogs_pkg::OGS_MODE_7TO1;
  assign m8 = mode_i == ogs_pkg::OGS_MODE_8TO1;
  assign m4 = mode_i == ogs_pkg::OGS_MODE_DUAL_4TO1;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  AST_RST_LOW: assert property ($fell(reset_i) |-> !serial_first_o && !serial_second_o && !word_taken_o)
    else $error("outputs not low after reset");
  AST_PER8: assert property (m8 && word_taken_o |=> !word_taken_o [*7] ##1 word_taken_o)
    else $error("8:1 period");
  AST_PER7: assert property (m7 && word_taken_o |=> !word_taken_o [*6] ##1 word_taken_o)
    else $error("7:1 period");
  AST_PER4: assert property (m4 && word_taken_o |=> !word_taken_o [*3] ##1 word_taken_o)
    else $error("4:1 period");
  AST_LSB8: assert property (m8 && word_taken_o |-> ##10 serial_first_o == $past(data_i[0], 10))
    else $error("8:1 first bit");
  AST_MSB8: assert property (m8 && word_taken_o |-> ##17 serial_first_o == $past(data_i[7], 17))
    else $error("8:1 last bit");
  AST_MSB7: assert property (m7 && word_taken_o |-> ##15 serial_first_o == $past(data_i[6], 15))
    else $error("7:1 last bit");
  AST_DUAL: assert property (m4 && word_taken_o |-> ##6 serial_second_o == $past(data_i[4], 6))
    else $error("4:1 second cell");
  AST_IDLE2: assert property (!m4 |-> !serial_second_o)
    else $error("second cell not idle");
endmodule : ogs_top_monitor
bind ogs_top ogs_top_monitor i_mon (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mode_i(mode_i), .data_i(data_i),
  .word_taken_o(word_taken_o), .serial_first_o(serial_first_o), .serial_second_o(serial_second_o));

/* test/ogs_core_model.sv */
`timescale 1ns/1ps
// core side: offers a fresh word after each capture pulse
module ogs_core_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // capture pulse and word
  input wire logic word_taken_i,
  output logic [7:0] data_o
);
  logic [7:0] idx_reg;
  // advance on capture only, so a word holds for its full period
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) idx_reg <= 8'h00;
    else if (word_taken_i) idx_reg <= idx_reg + 8'h01;
  end
  assign data_o = idx_reg * 8'h5B + 8'hA6;
endmodule : ogs_core_model

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  ogs_pkg::ogs_mode_t mode_i = ogs_pkg::OGS_MODE_7TO1;
  logic [7:0] data_i;
  logic word_taken_o, serial_first_o, serial_second_o;
  int mismatches = 0;
  int check_count = 0;
  // 125 MHz clock
  always #4 clk_sys_i = ~clk_sys_i;
  ogs_top i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mode_i(mode_i), .data_i(data_i),
    .word_taken_o(word_taken_o), .serial_first_o(serial_first_o), .serial_second_o(serial_second_o));
  ogs_core_model i_core (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .word_taken_i(word_taken_o), .data_o(data_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // reset into a mode, then follow three words out of the serial side
  task automatic run_mode(input ogs_pkg::ogs_mode_t m, input int n);
    logic [7:0] w;
    int i;
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    mode_i <= m;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    i = 0;
    do begin
      @(negedge clk_sys_i);
      chk({serial_second_o, serial_first_o}, 8'h00);
      i++;
    end while (word_taken_o !== 1'b1 && i < 20);
    chk(8'(i), 8'(n));
    // quiet through the shifter load plus the output retiming flop
    repeat (n + 1) begin
      @(negedge clk_sys_i);
      chk({serial_second_o, serial_first_o}, 8'h00);
    end
    for (int j = 0; j < 3; j++) begin
      w = 8'(j) * 8'h5B + 8'hA6;
      for (int k = 0; k < n; k++) begin
        @(negedge clk_sys_i);
        chk(serial_first_o, w[k]);
        chk(serial_second_o, (n == 4) ? w[k+4] : 1'b0);
        chk(word_taken_o, k == n - 2);
      end
    end
  endtask : run_mode
  task automatic end_sim;
    $display("mismatches=%0d checks=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // every mode code, the spare code behaving as 8:1
  initial begin
    run_mode(ogs_pkg::OGS_MODE_7TO1, 7);
    run_mode(ogs_pkg::OGS_MODE_8TO1, 8);
    run_mode(ogs_pkg::OGS_MODE_DUAL_4TO1, 4);
    run_mode(ogs_pkg::ogs_mode_t'(2'h3), 8);
    end_sim();
  end
  // hang guard, far beyond the roughly 170 cycles needed
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule : testbench
